/* inc/t8oc_map.vh */
// Register map, field positions, reset values and mode codes of the timer compare unit
`ifndef T8OC_MAP_VH
`define T8OC_MAP_VH

// Byte offsets on the register bus
`define T8OC_OFF_MODE 8'h00
`define T8OC_OFF_COUNT 8'h04
`define T8OC_OFF_CMP_A 8'h08
`define T8OC_OFF_CMP_B 8'h0C
`define T8OC_OFF_OUTCTL 8'h10
`define T8OC_OFF_FLAGS 8'h14
`define T8OC_OFF_IRQEN 8'h18
`define T8OC_OFF_PORTCTL 8'h1C
`define T8OC_OFF_STATUS 8'h20

// Field positions
`define T8OC_MODE_WGM_LSB 0
`define T8OC_MODE_CS_LSB 4
`define T8OC_OUT_FORCE_LSB 6
`define T8OC_FLAG_OVF 0
`define T8OC_FLAG_CMP_LSB 1
`define T8OC_PORT_DIR_LSB 2

// Reset values
`define T8OC_RST_BYTE 8'h00
`define T8OC_RST_COM 4'h0

// Waveform modes
`define T8OC_WGM_NORMAL 3'h0
`define T8OC_WGM_PHASE_FF 3'h1
`define T8OC_WGM_CTC 3'h2
`define T8OC_WGM_FAST_FF 3'h3
`define T8OC_WGM_PHASE_CMP 3'h5
`define T8OC_WGM_FAST_CMP 3'h7

// Compare output mode codes
`define T8OC_COM_OFF 2'h0
`define T8OC_COM_TOGGLE 2'h1
`define T8OC_COM_CLEAR 2'h2
`define T8OC_COM_SET 2'h3

// Counter limits
`define T8OC_MAX 8'hFF
`define T8OC_BOTTOM 8'h00

`endif

/* rtl/t8oc_counter.v */
// Prescaler and up or up-down counter of the timer
`timescale 1ns/1ps
`include "t8oc_map.vh"

module t8oc_counter
(
    input wire ref_clk,
    input wire rst_b,
    input wire [2:0] clk_sel,
    input wire up_down,
    input wire [7:0] top_val,
    input wire load,
    input wire [7:0] load_val,
    output wire [7:0] count,
    output wire tick,
    output wire dir_down,
    output wire top_evt,
    output wire bottom_evt
);
    reg [9:0] presc_reg;
    reg [7:0] count_reg;
    reg [7:0] count_next;
    reg dir_reg;
    reg dir_next;
    reg [9:0] mask;

    // Divider mask per clock select
    always @*
    begin
        case (clk_sel)
            3'h1: mask = 10'h000;
            3'h2: mask = 10'h007;
            3'h3: mask = 10'h01F;
            3'h4: mask = 10'h03F;
            3'h5: mask = 10'h07F;
            3'h6: mask = 10'h0FF;
            3'h7: mask = 10'h3FF;
            default: mask = 10'h000;
        endcase
    end

    assign tick = (clk_sel != 3'h0) && ((presc_reg & mask) == mask);
    assign count = count_reg;
    assign dir_down = dir_reg;
    assign top_evt = tick && (count_reg == top_val);
    assign bottom_evt = up_down ? (tick && dir_reg && (count_reg == `T8OC_BOTTOM)) : top_evt;

    // Next count and direction
    always @*
    begin
        count_next = count_reg;
        dir_next = dir_reg;
        if (!up_down)
            dir_next = 1'b0;
        if (load)
            count_next = load_val;
        else if (tick)
        begin
            if (!up_down)
                count_next = (count_reg == top_val) ? `T8OC_BOTTOM : count_reg + 8'h01;
            else if (dir_reg)
            begin
                if (count_reg == `T8OC_BOTTOM)
                begin
                    dir_next = 1'b0;
                    count_next = count_reg + 8'h01;
                end
                else
                    count_next = count_reg - 8'h01;
            end
            else if (count_reg == top_val)
            begin
                dir_next = 1'b1;
                count_next = count_reg - 8'h01;
            end
            else
                count_next = count_reg + 8'h01;
        end
    end

    // Prescaler and counter state
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            presc_reg <= 10'h000;
            count_reg <= `T8OC_RST_BYTE;
            dir_reg <= 1'b0;
        end
        else
        begin
            presc_reg <= presc_reg + 10'h001;
            count_reg <= count_next;
            dir_reg <= dir_next;
        end
    end
endmodule

/* rtl/t8oc_channel.v */
// One compare channel: buffered compare value and match detect
`timescale 1ns/1ps
`include "t8oc_map.vh"

module t8oc_channel
(
    input wire ref_clk,
    input wire rst_b,
    input wire wr_en,
    input wire [7:0] wr_data,
    input wire dbl_buf,
    input wire update,
    input wire [7:0] count,
    input wire tick,
    input wire block,
    output wire match,
    output wire [7:0] active,
    output wire [7:0] read_val
);
    reg [7:0] buf_reg;
    reg [7:0] active_reg;

    assign active = active_reg;
    assign read_val = dbl_buf ? buf_reg : active_reg;
    assign match = tick && !block && (count == active_reg);

    // Buffer and active compare value
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            buf_reg <= `T8OC_RST_BYTE;
            active_reg <= `T8OC_RST_BYTE;
        end
        else
        begin
            if (wr_en)
                buf_reg <= wr_data;
            if (wr_en && !dbl_buf)
                active_reg <= wr_data;
            else if (dbl_buf && update)
                active_reg <= buf_reg;
        end
    end
endmodule

/* rtl/t8oc_top.v */
// Eight-bit timer output compare unit with a classic Wishbone register slave
//
// How it works
// - PWM modes write compare value into buffer
// - Normal and clear-on-match write compare directly
// - Buffer copies to active at top/bottom
// - Bus reaches buffer or active per mode
// - Force strobe acts as match outside PWM
// - Forced compare sets no flag, keeps counter
// - Forced compare applies mode bits like match
// - Counter write blocks next timer-clock match
// - Output state survives waveform mode changes
// - Mode bits act at once, unbuffered
// - Mode bits pick output state on match
// - Mode bits pick pin source
// - Output state is internal register, not pin
// - Match sets flag; vector or write-one clears
// - Request needs enable, global enable, flag
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "t8oc_map.vh"

module t8oc_top
#(
    parameter CHANNELS = 2
)
(
    input wire ref_clk,
    input wire rst_b,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire global_irq_enable,
    input wire [1:0] vector_ack,
    output wire [1:0] compare_irq,
    output wire overflow_irq,
    output wire [1:0] oc_pin_out,
    output wire [1:0] oc_pin_oe
);
    reg ack_reg;
    reg [31:0] dat_reg;
    reg [31:0] dat_next;
    reg [2:0] wgm_reg;
    reg [2:0] cs_reg;
    reg [3:0] com_reg;
    reg [2:0] flag_reg;
    reg [2:0] flag_next;
    reg [2:0] irqen_reg;
    reg [1:0] port_data_reg;
    reg [1:0] port_dir_reg;
    reg block_reg;
    reg [1:0] oc_reg;
    reg [1:0] oc_next;
    reg [1:0] pin_out_reg;
    reg [1:0] pin_next;
    reg [1:0] pin_oe_reg;

    wire req;
    wire wr_take;
    wire wr_lane;
    wire [7:0] wbyte;
    wire wr_mode;
    wire wr_count;
    wire wr_outctl;
    wire wr_flags;
    wire wr_irqen;
    wire wr_port;
    wire [1:0] wr_cmp;
    wire [1:0] force_hit;
    wire is_phase;
    wire is_fast;
    wire is_pwm;
    wire top_is_cmp;
    wire [7:0] top_val;
    wire [7:0] count;
    wire tick;
    wire dir_down;
    wire top_evt;
    wire bottom_evt;
    wire update;
    wire ovf_evt;
    wire [1:0] match;
    wire [7:0] active_a;
    wire [7:0] active_b;
    wire [7:0] read_a;
    wire [7:0] read_b;

    // Bus request decode; a write lands on the edge where ack is high
    assign req = wb_cyc_i && wb_stb_i;
    assign wr_take = req && wb_we_i && ack_reg;
    assign wr_lane = wr_take && wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];
    assign wr_mode = wr_lane && (wb_adr_i == `T8OC_OFF_MODE);
    assign wr_count = wr_lane && (wb_adr_i == `T8OC_OFF_COUNT);
    assign wr_cmp[0] = wr_lane && (wb_adr_i == `T8OC_OFF_CMP_A);
    assign wr_cmp[1] = wr_lane && (wb_adr_i == `T8OC_OFF_CMP_B);
    assign wr_outctl = wr_lane && (wb_adr_i == `T8OC_OFF_OUTCTL);
    assign wr_flags = wr_lane && (wb_adr_i == `T8OC_OFF_FLAGS);
    assign wr_irqen = wr_lane && (wb_adr_i == `T8OC_OFF_IRQEN);
    assign wr_port = wr_lane && (wb_adr_i == `T8OC_OFF_PORTCTL);

    // Force strobes only count outside PWM modes
    assign force_hit = (wr_outctl && !is_pwm) ?
        wbyte[`T8OC_OUT_FORCE_LSB+1:`T8OC_OUT_FORCE_LSB] : 2'b00;

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // Waveform mode classes
    assign is_phase = (wgm_reg == `T8OC_WGM_PHASE_FF) || (wgm_reg == `T8OC_WGM_PHASE_CMP);
    assign is_fast = (wgm_reg == `T8OC_WGM_FAST_FF) || (wgm_reg == `T8OC_WGM_FAST_CMP);
    assign is_pwm = is_phase || is_fast;
    assign top_is_cmp = (wgm_reg == `T8OC_WGM_CTC) || (wgm_reg == `T8OC_WGM_PHASE_CMP)
        || (wgm_reg == `T8OC_WGM_FAST_CMP);
    assign top_val = top_is_cmp ? active_a : `T8OC_MAX;

    // Buffered compare values follow top in phase mode, bottom in fast mode
    assign update = is_phase ? top_evt : bottom_evt;
    assign ovf_evt = is_pwm ? bottom_evt : (tick && (count == `T8OC_MAX));

    t8oc_counter u_counter
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_sel(cs_reg),
        .up_down(is_phase),
        .top_val(top_val),
        .load(wr_count),
        .load_val(wbyte),
        .count(count),
        .tick(tick),
        .dir_down(dir_down),
        .top_evt(top_evt),
        .bottom_evt(bottom_evt)
    );

    t8oc_channel u_chan_a
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .wr_en(wr_cmp[0]),
        .wr_data(wbyte),
        .dbl_buf(is_pwm),
        .update(update),
        .count(count),
        .tick(tick),
        .block(block_reg),
        .match(match[0]),
        .active(active_a),
        .read_val(read_a)
    );

    t8oc_channel u_chan_b
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .wr_en(wr_cmp[1]),
        .wr_data(wbyte),
        .dbl_buf(is_pwm),
        .update(update),
        .count(count),
        .tick(tick),
        .block(block_reg),
        .match(match[1]),
        .active(active_b),
        .read_val(read_b)
    );

    // Output state and pin source per channel
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi = gi + 1)
        begin : g_out
            wire [1:0] com;
            wire cmp_toggle_ok;
            // Mode bits written in this cycle act at once, a force in the same write too
            assign com = wr_outctl ? wbyte[2*gi+1:2*gi] : com_reg[2*gi+1:2*gi];
            // Toggle in PWM only for channel A when it sets the top
            assign cmp_toggle_ok = (gi == 0) && top_is_cmp;

            // Next internal output state
            always @*
            begin
                oc_next[gi] = oc_reg[gi];
                if (!is_pwm)
                begin
                    if (match[gi] || force_hit[gi])
                    begin
                        case (com)
                            `T8OC_COM_TOGGLE: oc_next[gi] = ~oc_reg[gi];
                            `T8OC_COM_CLEAR: oc_next[gi] = 1'b0;
                            `T8OC_COM_SET: oc_next[gi] = 1'b1;
                            default: oc_next[gi] = oc_reg[gi];
                        endcase
                    end
                end
                else if (is_fast)
                begin
                    if (match[gi])
                    begin
                        case (com)
                            `T8OC_COM_TOGGLE: oc_next[gi] = cmp_toggle_ok ? ~oc_reg[gi] : oc_reg[gi];
                            `T8OC_COM_CLEAR: oc_next[gi] = 1'b0;
                            `T8OC_COM_SET: oc_next[gi] = 1'b1;
                            default: oc_next[gi] = oc_reg[gi];
                        endcase
                    end
                    if (bottom_evt && com[1])
                        oc_next[gi] = (com == `T8OC_COM_CLEAR);
                end
                else if (match[gi])
                begin
                    case (com)
                        `T8OC_COM_TOGGLE: oc_next[gi] = cmp_toggle_ok ? ~oc_reg[gi] : oc_reg[gi];
                        `T8OC_COM_CLEAR: oc_next[gi] = dir_down;
                        `T8OC_COM_SET: oc_next[gi] = !dir_down;
                        default: oc_next[gi] = oc_reg[gi];
                    endcase
                end
            end

            // Pin takes the output state unless mode bits leave it to the port
            always @*
            begin
                if ((com == `T8OC_COM_OFF) || (is_pwm && (com == `T8OC_COM_TOGGLE)
                    && !cmp_toggle_ok))
                    pin_next[gi] = port_data_reg[gi];
                else
                    pin_next[gi] = oc_reg[gi];
            end
        end
    endgenerate

    // Flags: hardware set wins over vector or write-one clear
    always @*
    begin
        flag_next = flag_reg;
        if (wr_flags)
            flag_next = flag_reg & ~wbyte[2:0];
        flag_next[`T8OC_FLAG_CMP_LSB+1:`T8OC_FLAG_CMP_LSB] =
            flag_next[`T8OC_FLAG_CMP_LSB+1:`T8OC_FLAG_CMP_LSB] & ~vector_ack;
        flag_next[`T8OC_FLAG_OVF] = flag_next[`T8OC_FLAG_OVF] | ovf_evt;
        // Only real matches set a compare flag; forcing never does
        flag_next[`T8OC_FLAG_CMP_LSB+1:`T8OC_FLAG_CMP_LSB] =
            flag_next[`T8OC_FLAG_CMP_LSB+1:`T8OC_FLAG_CMP_LSB] | match;
    end

    // Requests need enable, global enable and flag together
    assign compare_irq = flag_reg[`T8OC_FLAG_CMP_LSB+1:`T8OC_FLAG_CMP_LSB]
        & irqen_reg[`T8OC_FLAG_CMP_LSB+1:`T8OC_FLAG_CMP_LSB]
        & {2{global_irq_enable}};
    assign overflow_irq = flag_reg[`T8OC_FLAG_OVF] && irqen_reg[`T8OC_FLAG_OVF]
        && global_irq_enable;

    assign oc_pin_out = pin_out_reg;
    assign oc_pin_oe = pin_oe_reg;

    // Read data mux, loaded as ack rises
    always @*
    begin
        dat_next = 32'h00000000;
        case (wb_adr_i)
            `T8OC_OFF_MODE: dat_next[7:0] = {1'b0, cs_reg, 1'b0, wgm_reg};
            `T8OC_OFF_COUNT: dat_next[7:0] = count;
            `T8OC_OFF_CMP_A: dat_next[7:0] = read_a;
            `T8OC_OFF_CMP_B: dat_next[7:0] = read_b;
            `T8OC_OFF_OUTCTL: dat_next[7:0] = {4'h0, com_reg};
            `T8OC_OFF_FLAGS: dat_next[7:0] = {5'h00, flag_reg};
            `T8OC_OFF_IRQEN: dat_next[7:0] = {5'h00, irqen_reg};
            `T8OC_OFF_PORTCTL: dat_next[7:0] = {4'h0, port_dir_reg, port_data_reg};
            `T8OC_OFF_STATUS: dat_next[7:0] = {4'h0, block_reg, dir_down, oc_reg};
            default: dat_next = 32'h00000000;
        endcase
    end

    // Bus handshake: one wait cycle, ack for one cycle
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end
        else
        begin
            ack_reg <= req && !ack_reg;
            if (req && !ack_reg && !wb_we_i)
                dat_reg <= dat_next;
        end
    end

    // Control registers
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wgm_reg <= `T8OC_WGM_NORMAL;
            cs_reg <= 3'h0;
            com_reg <= `T8OC_RST_COM;
            irqen_reg <= 3'h0;
            port_data_reg <= 2'h0;
            port_dir_reg <= 2'h0;
        end
        else
        begin
            if (wr_mode)
            begin
                wgm_reg <= wbyte[`T8OC_MODE_WGM_LSB+2:`T8OC_MODE_WGM_LSB];
                cs_reg <= wbyte[`T8OC_MODE_CS_LSB+2:`T8OC_MODE_CS_LSB];
            end
            if (wr_outctl)
                com_reg <= wbyte[3:0];
            if (wr_irqen)
                irqen_reg <= wbyte[2:0];
            if (wr_port)
            begin
                port_data_reg <= wbyte[1:0];
                port_dir_reg <= wbyte[`T8OC_PORT_DIR_LSB+1:`T8OC_PORT_DIR_LSB];
            end
        end
    end

    // Match blocking after a counter write, held until the next timer tick
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            block_reg <= 1'b0;
        else if (wr_count)
            block_reg <= 1'b1;
        else if (tick)
            block_reg <= 1'b0;
    end

    // Output state, flags and pin drivers
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            oc_reg <= 2'h0;
            flag_reg <= 3'h0;
            pin_out_reg <= 2'h0;
            pin_oe_reg <= 2'h0;
        end
        else
        begin
            oc_reg <= oc_next;
            flag_reg <= flag_next;
            pin_out_reg <= pin_next;
            pin_oe_reg <= port_dir_reg;
        end
    end
endmodule

/* testbench/t8oc_props.sv */
// Port-level assertions for the timer compare unit
`timescale 1ns/1ps
`include "t8oc_map.vh"

module t8oc_props
(
    input wire ref_clk,
    input wire rst_b,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire global_irq_enable,
    input wire [1:0] compare_irq,
    input wire overflow_irq,
    input wire [1:0] oc_pin_oe
);
    // Accepted write to the port control register
    wire port_wr = wb_ack_o & wb_we_i & wb_sel_i[0] & (wb_adr_i == `T8OC_OFF_PORTCTL);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // Bus handshake
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_dat_upper_zero: assert property (wb_dat_o[31:8] == 24'h000000)
        else $error("upper read data bits not zero");
    a_dat_on_ack: assert property ($changed(wb_dat_o) |-> wb_ack_o)
        else $error("read data moved outside an ack");
    // Interrupt gating
    a_irq_needs_global: assert property (|compare_irq |-> global_irq_enable)
        else $error("compare request while global enable low");
    a_ovf_needs_global: assert property (overflow_irq |-> global_irq_enable)
        else $error("overflow request while global enable low");
    // Pin enable follows only a port control write
    a_oe_after_write: assert property ($changed(oc_pin_oe) |-> $past(port_wr) || $past(port_wr, 2))
        else $error("pin enable changed without a port write");
endmodule

/* testbench/tb.sv */
// Directed testbench of the timer compare unit over Wishbone
`timescale 1ns/1ps

module tb;
    logic ref_clk;
    logic rst_b;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic global_irq_enable;
    logic [1:0] vector_ack;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    wire [1:0] compare_irq;
    wire overflow_irq;
    wire [1:0] oc_pin_out;
    wire [1:0] oc_pin_oe;
    logic [31:0] rdat;
    logic [7:0] fcode [5] = '{8'h03, 8'h00, 8'h02, 8'h01, 8'h01};
    logic [7:0] fexp [5] = '{8'h01, 8'h01, 8'h00, 8'h01, 8'h00};
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    int i;

    t8oc_top #(.CHANNELS(2)) i_t8oc_top (.ref_clk(ref_clk), .rst_b(rst_b),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
        .compare_irq(compare_irq), .overflow_irq(overflow_irq),
        .oc_pin_out(oc_pin_out), .oc_pin_oe(oc_pin_oe));

    // Clock, 4 ns period
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Verdict and end of run
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", total_checks, miscompares);
            if (miscompares == 0 && total_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    // Hang guard
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            miscompares = miscompares + 1;
            end_sim;
        end
    end

    // Byte comparison
    task chk(input [7:0] act, input [7:0] exp);
        begin
            total_checks = total_checks + 1;
            if (act !== exp)
            begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: got %h expected %h", $time, act, exp);
            end
        end
    endtask

    // One classic Wishbone cycle, held until ack
    task bus(input logic w, input [7:0] a, input [7:0] d);
        begin
            @(posedge ref_clk);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= w;
            wb_adr_i <= a;
            wb_sel_i <= 4'h1;
            wb_dat_i <= {24'h000000, d};
            @(posedge ref_clk);
            while (wb_ack_o !== 1'b1)
                @(posedge ref_clk);
            rdat = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask

    task wr(input [7:0] a, input [7:0] d);
        bus(1'b1, a, d);
    endtask

    task rd(input [7:0] a, input [7:0] exp);
        begin
            bus(1'b0, a, 8'h00);
            chk(rdat[7:0], exp);
        end
    endtask

    // Run the timer for n clocks, then stop it in the same waveform mode
    task run(input [7:0] m, input int n);
        begin
            wr(8'h00, m);
            repeat (n) @(posedge ref_clk);
            wr(8'h00, m & 8'h07);
        end
    endtask

    // Offsets: 00 mode, 04 count, 08 cmp A, 10 outctl, 14 flags, 18 irqen, 1C port, 20 status
    initial
    begin
        rst_b = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
        global_irq_enable = 1'b0;
        vector_ack = 2'h0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (i = 0; i < 10; i++)
            rd(8'(i * 4), 8'h00);
        chk({4'h0, oc_pin_oe, oc_pin_out}, 8'h00);
        $display("reset values done");
        for (i = 0; i < 5; i++)
        begin
            wr(8'h10, 8'h40 | fcode[i]);
            rd(8'h20, fexp[i]);
        end
        wr(8'h10, 8'h8C);
        rd(8'h20, 8'h02);
        rd(8'h14, 8'h00);
        rd(8'h04, 8'h00);
        $display("forced compare done");
        wr(8'h10, 8'h43);
        wr(8'h00, 8'h03);
        rd(8'h20, 8'h03);
        wr(8'h10, 8'h42);
        rd(8'h20, 8'h03);
        wr(8'h00, 8'h00);
        rd(8'h20, 8'h03);
        $display("mode change done");
        wr(8'h08, 8'h40);
        rd(8'h08, 8'h40);
        wr(8'h10, 8'h42);
        rd(8'h20, 8'h02);
        wr(8'h10, 8'h03);
        wr(8'h1C, 8'h04);
        wr(8'h04, 8'h40);
        run(8'h10, 100);
        rd(8'h14, 8'h00);
        rd(8'h20, 8'h02);
        wr(8'h04, 8'h3F);
        run(8'h10, 100);
        rd(8'h14, 8'h02);
        rd(8'h20, 8'h03);
        repeat (2) @(posedge ref_clk);
        chk({4'h0, oc_pin_oe, oc_pin_out}, 8'h05);
        wr(8'h10, 8'h00);
        repeat (2) @(posedge ref_clk);
        chk({4'h0, oc_pin_oe, oc_pin_out}, 8'h04);
        rd(8'h20, 8'h03);
        $display("match and blocking done");
        wr(8'h18, 8'h02);
        chk({6'h00, compare_irq}, 8'h00);
        @(posedge ref_clk);
        global_irq_enable <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({6'h00, compare_irq}, 8'h01);
        vector_ack <= 2'h1;
        @(posedge ref_clk);
        vector_ack <= 2'h0;
        @(posedge ref_clk);
        chk({6'h00, compare_irq}, 8'h00);
        rd(8'h14, 8'h00);
        $display("interrupt done");
        wr(8'h00, 8'h03);
        wr(8'h08, 8'h80);
        rd(8'h08, 8'h80);
        wr(8'h04, 8'h3E);
        run(8'h13, 20);
        rd(8'h14, 8'h02);
        wr(8'h14, 8'h07);
        rd(8'h14, 8'h00);
        wr(8'h04, 8'hF0);
        run(8'h13, 100);
        rd(8'h14, 8'h05);
        wr(8'h14, 8'h07);
        wr(8'h04, 8'h7E);
        run(8'h13, 20);
        rd(8'h14, 8'h02);
        $display("buffered compare done");
        wr(8'h08, 8'h20);
        wr(8'h10, 8'h03);
        wr(8'h04, 8'hF8);
        run(8'h11, 20);
        rd(8'h20, 8'h07);
        wr(8'h14, 8'h07);
        wr(8'h04, 8'h30);
        run(8'h11, 20);
        rd(8'h14, 8'h02);
        rd(8'h20, 8'h06);
        wr(8'h14, 8'h07);
        wr(8'h18, 8'h01);
        run(8'h11, 40);
        rd(8'h14, 8'h05);
        chk({7'h00, overflow_irq}, 8'h01);
        $display("phase correct done");
        end_sim;
    end
endmodule

bind t8oc_top t8oc_props i_t8oc_props (.ref_clk(ref_clk), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .global_irq_enable(global_irq_enable), .compare_irq(compare_irq),
    .overflow_irq(overflow_irq), .oc_pin_oe(oc_pin_oe));
